// ==== chan_cfg_defs.vh ====
// Constants for the channel configuration word decoder.
// Assumes inclusion by the two design files and the testbench; holds definitions only.
`ifndef CHAN_CFG_DEFS_VH
`define CHAN_CFG_DEFS_VH

// ==========================================================================
// Register byte addresses
`define ADDR_CFG_WORD 12'h000
`define ADDR_LIMITS 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_IRQ_STATUS 12'h00c
`define ADDR_IRQ_MASK 12'h010

// ==========================================================================
// Configuration word fields
`define BIT_PAD_ADJ 31
`define FLD_FIFO_START_HI 29
`define FLD_FIFO_START_LO 24
`define BIT_INVERT 23
`define FLD_FIFO_LEN_HI 21
`define FLD_FIFO_LEN_LO 16
`define BIT_PADFILL_IRQ 15
`define FLD_PROTO_HI 14
`define FLD_PROTO_LO 12
`define FLD_MAX_LENGTH_SELECT_HI 11
`define FLD_MAX_LENGTH_SELECT_LO 10
`define CFG_WRITABLE_MASK 32'hbfbffc00
`define CFG_RESET 32'h00000000

// ==========================================================================
// Encodings
`define PROTO_TRANSPARENT 3'h0
`define PROTO_SS7_FCS16 3'h1
`define PROTO_HDLC_FCS16 3'h2
`define PROTO_HDLC_FCS32 3'h3
`define MAX_LENGTH_SELECT_NONE 2'h0
`define MAX_LENGTH_SELECT_ONE 2'h1
`define MAX_LENGTH_SELECT_TWO 2'h2
`define MAX_LENGTH_SELECT_RSVD 2'h3

// ==========================================================================
// Interrupt status bits
`define IRQ_PADFILL_END 0
`define IRQ_TOO_LONG 1
`define IRQ_BAD_CONFIG 2
`define IRQ_RESET 3'h0

`endif

// ==== length_check.v ====
// Receive message length checker for one channel direction.
// Assumes byte strobes and message boundaries come from the framing engine.
`timescale 1ns/100ps
`include "chan_cfg_defs.vh"
module length_check #(
  parameter LEN_W = 14
) (
  input wire pclk,
  input wire presetn,
  input wire [1:0] max_length_select,
  input wire [LEN_W-1:0] length_limit_one,
  input wire [LEN_W-1:0] length_limit_two,
  input wire rx_byte,
  input wire rx_msg_end,
  output wire too_long,
  output reg [LEN_W-1:0] byte_count_q
);
  reg [LEN_W-1:0] limit;
  reg check_on;
  reg [LEN_W-1:0] byte_count_d;

  always @* begin
    limit = {LEN_W{1'b0}};
    check_on = 1'b0;
    case (max_length_select)
      `MAX_LENGTH_SELECT_ONE: begin
        limit = length_limit_one;
        check_on = 1'b1;
      end
      `MAX_LENGTH_SELECT_TWO: begin
        limit = length_limit_two;
        check_on = 1'b1;
      end
      default: begin
        check_on = 1'b0;
      end
    endcase
  end

  always @* begin
    byte_count_d = byte_count_q;
    if (rx_msg_end) begin
      byte_count_d = {LEN_W{1'b0}};
    end else if (rx_byte && (byte_count_q != {LEN_W{1'b1}})) begin
      byte_count_d = byte_count_q + {{(LEN_W-1){1'b0}}, 1'b1};
    end
  end

  // Pulses on the byte that first crosses the limit; an all-ones limit pulses on every byte once the count saturates.
  assign too_long = check_on && rx_byte && !rx_msg_end && (byte_count_q == limit);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_count_q <= {LEN_W{1'b0}};
    end else begin
      byte_count_q <= byte_count_d;
    end
  end
endmodule

// ==== chan_cfg_word.v ====
// Holds and decodes bits 31:10 of one channel configuration word.
// Assumes an APB master on pclk and a framing engine on the same clock.
//
// Functional notes
// - bit 31 set lets detected zero insertion reduce the pad count.
// - bits 29:24 give the starting index of the channel FIFO slice.
// - bit 23 clear passes data bits through uninverted.
// - FIFO slice size in dwords is twice bits 21:16 plus two.
// - bit 15 enables the transmit end-of-padfill interrupt.
// - length select zero disables receive length checking; three is reserved.
// - length select one uses the first length limit.
// - length select two uses the second length limit.
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "chan_cfg_defs.vh"
module chan_cfg_word #(
  parameter LEN_W = 14,
  parameter PAD_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [PAD_W-1:0] pad_count_load,
  input wire pad_count_load_en,
  input wire zero_insert_seen,
  output reg [PAD_W-1:0] pad_count,
  input wire [7:0] tx_data_in,
  input wire [7:0] rx_data_in,
  output reg [7:0] tx_data_out,
  output reg [7:0] rx_data_out,
  input wire tx_padfill_done,
  input wire rx_byte,
  input wire rx_msg_end,
  output reg [5:0] fifo_start_index,
  output reg [6:0] fifo_slice_dwords,
  output reg [2:0] protocol_select,
  output reg [1:0] max_length_select,
  output reg padfill_end_irq_enable,
  output reg data_invert,
  output reg pad_adjust_enable,
  output wire rx_too_long,
  output wire irq
);
  // ========================================================================
  // Register storage
  reg [31:0] cfg_q;
  reg [LEN_W-1:0] limit_one_q;
  reg [LEN_W-1:0] limit_two_q;
  reg [2:0] irq_status_q;
  reg [2:0] irq_status_d;
  reg [2:0] irq_mask_q;
  reg [PAD_W-1:0] pad_q;
  reg [PAD_W-1:0] pad_d;
  wire [LEN_W-1:0] byte_count;
  wire wr_en;
  wire rd_en;
  wire hit;
  wire bad_cfg;
  wire [2:0] irq_events;

  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign hit = (paddr == `ADDR_CFG_WORD) || (paddr == `ADDR_LIMITS) ||
               (paddr == `ADDR_STATUS) || (paddr == `ADDR_IRQ_STATUS) ||
               (paddr == `ADDR_IRQ_MASK);
  assign pslverr = psel && penable && !hit;

  // ========================================================================
  // Writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `CFG_RESET;
      limit_one_q <= {LEN_W{1'b0}};
      limit_two_q <= {LEN_W{1'b0}};
      irq_mask_q <= `IRQ_RESET;
    end else if (wr_en) begin
      case (paddr)
        `ADDR_CFG_WORD: begin
          cfg_q <= pwdata & `CFG_WRITABLE_MASK;
        end
        `ADDR_LIMITS: begin
          limit_one_q <= pwdata[LEN_W-1:0];
          limit_two_q <= pwdata[LEN_W+15:16];
        end
        `ADDR_IRQ_MASK: begin
          irq_mask_q <= pwdata[2:0];
        end
        default: begin
          cfg_q <= cfg_q;
        end
      endcase
    end
  end

  // ========================================================================
  // Field decode
  always @* begin
    pad_adjust_enable = cfg_q[`BIT_PAD_ADJ];
    fifo_start_index = cfg_q[`FLD_FIFO_START_HI:`FLD_FIFO_START_LO];
    data_invert = cfg_q[`BIT_INVERT];
    // A length code of 63 asks for 128 dwords, which wraps to 0 in seven bits.
    // The allocator must read a slice size of 0 as 128 dwords.
    fifo_slice_dwords = {cfg_q[`FLD_FIFO_LEN_HI:`FLD_FIFO_LEN_LO], 1'b0} + 7'h02;
    padfill_end_irq_enable = cfg_q[`BIT_PADFILL_IRQ];
    protocol_select = cfg_q[`FLD_PROTO_HI:`FLD_PROTO_LO];
    max_length_select = cfg_q[`FLD_MAX_LENGTH_SELECT_HI:`FLD_MAX_LENGTH_SELECT_LO];
  end

  // Reserved codes are still passed on, but flagged so software notices.
  assign bad_cfg = protocol_select[2] || (max_length_select == `MAX_LENGTH_SELECT_RSVD);

  // ========================================================================
  // Data path inversion
  always @* begin
    if (data_invert) begin
      tx_data_out = ~tx_data_in;
      rx_data_out = ~rx_data_in;
    end else begin
      tx_data_out = tx_data_in;
      rx_data_out = rx_data_in;
    end
  end

  // ========================================================================
  // Pad count
  always @* begin
    pad_d = pad_q;
    if (pad_count_load_en) begin
      pad_d = pad_count_load;
    end else if (pad_adjust_enable && zero_insert_seen && (pad_q != {PAD_W{1'b0}})) begin
      pad_d = pad_q - {{(PAD_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_q <= {PAD_W{1'b0}};
    end else begin
      pad_q <= pad_d;
    end
  end

  always @* begin
    pad_count = pad_q;
  end

  // ========================================================================
  // Length checker
  length_check #(
    .LEN_W(LEN_W)
  ) u_length_check (
    .pclk(pclk),
    .presetn(presetn),
    .max_length_select(max_length_select),
    .length_limit_one(limit_one_q),
    .length_limit_two(limit_two_q),
    .rx_byte(rx_byte),
    .rx_msg_end(rx_msg_end),
    .too_long(rx_too_long),
    .byte_count_q(byte_count)
  );

  // ========================================================================
  // Interrupts
  assign irq_events = {bad_cfg, rx_too_long, tx_padfill_done && padfill_end_irq_enable};

  always @* begin
    irq_status_d = irq_status_q;
    if (wr_en && (paddr == `ADDR_IRQ_STATUS)) begin
      irq_status_d = irq_status_q & ~pwdata[2:0];
    end
    // Setting after clearing means an event in the clear cycle survives.
    irq_status_d = irq_status_d | irq_events;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= `IRQ_RESET;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ========================================================================
  // Reads
  always @* begin
    prdata = 32'h00000000;
    if (rd_en) begin
      case (paddr)
        `ADDR_CFG_WORD: prdata = cfg_q;
        `ADDR_LIMITS: prdata = {{(16-LEN_W){1'b0}}, limit_two_q, {(16-LEN_W){1'b0}}, limit_one_q};
        `ADDR_STATUS: prdata = {{(16-PAD_W){1'b0}}, pad_q, {(16-LEN_W){1'b0}}, byte_count};
        `ADDR_IRQ_STATUS: prdata = {29'h0, irq_status_q};
        `ADDR_IRQ_MASK: prdata = {29'h0, irq_mask_q};
        default: prdata = 32'h00000000;
      endcase
    end
  end
endmodule

// ==== chan_cfg_asserts.sv ====
// Port assertions for the configuration word decoder.
// Assumes binding onto chan_cfg_word with default widths.
`timescale 1ns/100ps
module chan_cfg_asserts (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic zero_insert_seen,
  input logic pad_count_load_en,
  input logic [7:0] pad_count,
  input logic [7:0] tx_data_in,
  input logic [7:0] tx_data_out,
  input logic [7:0] rx_data_in,
  input logic [7:0] rx_data_out,
  input logic [5:0] fifo_start_index,
  input logic [6:0] fifo_slice_dwords,
  input logic [2:0] protocol_select,
  input logic [1:0] max_length_select,
  input logic padfill_end_irq_enable,
  input logic data_invert,
  input logic pad_adjust_enable,
  input logic rx_too_long
);
  // ==========================================================
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] wd_q;
  wire wr = psel && penable && pwrite && paddr == 12'h000;
  wire zi = zero_insert_seen && !pad_count_load_en;
  always @(posedge pclk) wd_q <= pwdata;
  inv_tx_a: assert property (tx_data_out == (tx_data_in ^ {8{data_invert}}))
    else $error("tx inversion wrong");
  inv_rx_a: assert property (rx_data_out == (rx_data_in ^ {8{data_invert}}))
    else $error("rx inversion wrong");
  pad_hold_a: assert property (zi && !pad_adjust_enable |=> $stable(pad_count))
    else $error("pad count moved");
  pad_step_a: assert property (zi && pad_adjust_enable && pad_count != 8'h00 |=>
    pad_count == $past(pad_count) - 8'h01) else $error("pad count not reduced");
  cfg_loc_a: assert property (wr |=> fifo_start_index == wd_q[29:24])
    else $error("start index wrong");
  cfg_len_a: assert property (wr |=> fifo_slice_dwords == 7'(2 * (wd_q[21:16] + 1)))
    else $error("slice size wrong");
  cfg_mode_a: assert property (wr |=> {padfill_end_irq_enable, protocol_select} == wd_q[15:12])
    else $error("mode fields wrong");
  no_check_a: assert property (max_length_select inside {2'h0, 2'h3} |-> !rx_too_long)
    else $error("length check while off");
  cover property (wr);
  cover property (rx_too_long);
  cover property (zi && pad_adjust_enable);
endmodule
bind chan_cfg_word chan_cfg_asserts u_chk (.*);

// ==== frame_src.sv ====
// Framing engine stand-in: n received bytes on back-to-back cycles, then a message end.
// Assumes go is raised for one cycle while busy is low.
`timescale 1ns/100ps
module frame_src (
  input logic pclk,
  input logic go,
  input logic [7:0] n,
  output logic rx_byte,
  output logic rx_msg_end,
  output logic busy
);
  // ==========================================================
  // Burst counter
  logic [7:0] left_q = 8'h00;
  assign rx_byte = left_q > 8'h01;
  assign rx_msg_end = left_q == 8'h01;
  assign busy = left_q != 8'h00;
  always @(posedge pclk) left_q <= go ? n + 8'h01 : left_q - (left_q != 8'h00);
endmodule

// ==== chan_cfg_word_tb.sv ====
// Self-checking bench for the configuration word decoder.
// Assumes frame_src stands in for the framing engine.
`timescale 1ns/100ps
`include "chan_cfg_defs.vh"
module chan_cfg_word_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic zero_insert_seen = 1'b0, pad_count_load_en = 1'b0, go = 1'b0, perr;
  logic tx_padfill_done = 1'b0;
  logic [7:0] tx_in = 8'h5a;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, w;
  logic [7:0] pad_count, tx_data_out, rx_data_out, n = 8'h05;
  logic [6:0] fifo_slice_dwords;
  logic [5:0] fifo_start_index;
  logic [2:0] protocol_select;
  logic [1:0] max_length_select;
  logic pready, pslverr, rx_byte, rx_msg_end, busy, rx_too_long, irq;
  logic padfill_end_irq_enable, data_invert, pad_adjust_enable;
  int mismatches = 0, cmp_count = 0, hits = 0, t;
  always #25 pclk = ~pclk;
  always @(posedge pclk) if (rx_too_long === 1'b1) hits++;
  chan_cfg_word i_dut (.*, .pad_count_load(8'h03), .tx_data_in(tx_in), .rx_data_in(8'h3c),
    .tx_padfill_done(tx_padfill_done));
  frame_src i_src (.*);
  // ==========================================================
  // Tasks
  task automatic finish_test(input int bad);
    mismatches += bad;
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 20; t++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    perr = pslverr;
    if (t == 20) finish_test(1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic burst(input logic [7:0] len);
    hits = 0;
    @(posedge pclk);
    n <= len;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (t = 0; t < 40; t++) begin
      @(posedge pclk);
      if (busy !== 1'b1) break;
    end
    if (t == 40) finish_test(1);
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ADDR_CFG_WORD, 32'h0);
    chk("cfg reset", `CFG_RESET, rd);
    for (int i = 0; i < 8; i++) begin
      w = {i[2], 1'b1, 6'(i * 9), i[0], 1'b1, 6'(63 - i), i[1], i[2:0], i[1:0], 10'h3ff};
      tx_in <= 8'(i * 37 + 5);
      apb(1'b1, `ADDR_CFG_WORD, w);
      apb(1'b0, `ADDR_CFG_WORD, 32'h0);
      chk("cfg readback", w & `CFG_WRITABLE_MASK, rd);
      chk("decode", {w[31], w[23], w[15:10], w[29:24], 7'(2 * (w[21:16] + 1))},
        {pad_adjust_enable, data_invert, padfill_end_irq_enable, protocol_select,
        max_length_select, fifo_start_index, fifo_slice_dwords});
      chk("data out", {8'(i * 37 + 5) ^ {8{w[23]}}, 8'h3c ^ {8{w[23]}}},
        {tx_data_out, rx_data_out});
    end
    $display("decode test done");
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, `ADDR_CFG_WORD, {j[0], 31'h0});
      @(posedge pclk);
      pad_count_load_en <= 1'b1;
      @(posedge pclk);
      pad_count_load_en <= 1'b0;
      zero_insert_seen <= 1'b1;
      @(posedge pclk);
      zero_insert_seen <= 1'b0;
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk("pad count", {2{8'(3 - j)}}, {rd[23:16], pad_count});
    end
    $display("pad test done");
    // Limit two sits at the byte count of a five-byte message, so off-by-one shows.
    apb(1'b1, `ADDR_LIMITS, 32'h00050003);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, `ADDR_CFG_WORD, (k - (k > 2)) << 10);
      burst(8'h05 + (k == 3));
      chk("too long count", (k == 1 || k == 3), hits);
    end
    $display("length test done");
    apb(1'b1, `ADDR_CFG_WORD, 32'h00000400);
    apb(1'b1, `ADDR_IRQ_STATUS, 32'h7);
    burst(8'h05);
    apb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
    chk("irq masked", {32'h2, 1'b0}, {rd, irq});
    apb(1'b1, `ADDR_IRQ_MASK, 32'h2);
    apb(1'b0, 12'h014, 32'h0);
    chk("irq and unmapped", {32'h0, 2'h3}, {rd, perr, irq});
    apb(1'b1, `ADDR_IRQ_STATUS, 32'h2);
    apb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
    chk("irq cleared", {32'h0, 1'b0}, {rd, irq});
    apb(1'b1, `ADDR_IRQ_MASK, 32'h1);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, `ADDR_CFG_WORD, {16'h0, m[0], 15'h0});
      @(posedge pclk);
      tx_padfill_done <= 1'b1;
      @(posedge pclk);
      tx_padfill_done <= 1'b0;
      apb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
      chk("padfill irq", {31'h0, m[0], m[0]}, {rd, irq});
      apb(1'b1, `ADDR_IRQ_STATUS, 32'h1);
    end
    $display("register test done");
    finish_test(0);
  end
endmodule
